// *** hw/tmr_top.sv ***
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
module tmr_top
    import tmr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic globalIrqEn,
    input wire logic ackOvf,
    input wire logic ackCmpA,
    input wire logic ackCmpB,
    input wire logic extCountPin,
    input wire logic otherTimerTick,
    output logic irqOvf,
    output logic irqCmpA,
    output logic irqCmpB,
    output logic waveOutA,
    output logic waveOutB,
    output logic asyncPrescalerReset,
    output logic prescaleTick8,
    output logic prescaleTick64,
    output logic prescaleTick256,
    output logic prescaleTick1024
);
    // ---------------------------------------------------------------
    // Bus slave
    // ---------------------------------------------------------------
    logic wrPend;
    logic [7:0] wrAddr;
    logic [7:0] counterValue;
    logic [7:0] compareAValue;
    logic [7:0] compareBValue;
    logic [2:0] irqEnableBits;
    logic [2:0] irqFlagBits;
    logic syncHoldMode;
    logic syncPrescalerReset;
    logic [2:0] clockSrcSel;
    logic [2:0] waveModeSel;
    logic countDown;
    logic blockMatch;
    logic tick;
    logic rise;
    logic fall;
    logic t8;
    logic t64;
    logic t256;
    logic t1024;
    logic addrPhase;
    logic wrCounter;
    logic wrFlag;
    logic wrSync;
    logic matchA;
    logic matchB;
    logic ovfEvent;
    logic [7:0] top;
    logic [7:0] next_count;
    logic next_down;
    tmr_wave_t wm;

    assign addrPhase = hsel && hready && htrans[1];
    assign wrCounter = wrPend && (wrAddr == ADDR_COUNTER);
    assign wrFlag = wrPend && (wrAddr == ADDR_IRQ_FLAG);
    assign wrSync = wrPend && (wrAddr == ADDR_SYNC_CTRL);
    assign wm = tmr_wave_t'(waveModeSel);

    // Zero wait states; data phase always finishes in one cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wrPend <= addrPhase && hwrite;
            wrAddr <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data registered in the address phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            case (haddr[7:0])
                ADDR_COUNTER: hrdata <= {24'h000000, counterValue};
                ADDR_CMP_A: hrdata <= {24'h000000, compareAValue};
                ADDR_CMP_B: hrdata <= {24'h000000, compareBValue};
                ADDR_IRQ_EN: hrdata <= {29'h00000000, irqEnableBits};
                ADDR_IRQ_FLAG: hrdata <= {29'h00000000, irqFlagBits};
                ADDR_SYNC_CTRL: hrdata <= {24'h000000, syncHoldMode, 5'h00,
                                           asyncPrescalerReset, syncPrescalerReset};
                ADDR_CONTROL: hrdata <= {25'h0000000, waveModeSel, 1'b0, clockSrcSel};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            compareAValue <= RESET_BYTE;
            compareBValue <= RESET_BYTE;
            irqEnableBits <= 3'h0;
            clockSrcSel <= CS_STOP;
            waveModeSel <= 3'h0;
        end else if (wrPend) begin
            case (wrAddr)
                ADDR_CMP_A: compareAValue <= hwdata[7:0];
                ADDR_CMP_B: compareBValue <= hwdata[7:0];
                ADDR_IRQ_EN: irqEnableBits <= hwdata[2:0];
                ADDR_CONTROL: begin
                    clockSrcSel <= hwdata[CTRL_CS_LSB +: 3];
                    waveModeSel <= hwdata[CTRL_WGM_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Prescaler reset and hold mode
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syncHoldMode <= 1'b0;
        end else if (wrSync) begin
            syncHoldMode <= hwdata[BIT_SYNC_HOLD];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syncPrescalerReset <= 1'b0;
            asyncPrescalerReset <= 1'b0;
        end else if (wrSync) begin
            // Dropping hold mode clears both reset bits, unless the same write sets the sync bit, which then holds for one cycle
            syncPrescalerReset <= hwdata[BIT_SYNC_HOLD] &&
                                  (hwdata[BIT_PSR_SYNC] || syncPrescalerReset);
            asyncPrescalerReset <= hwdata[BIT_SYNC_HOLD] &&
                                   (hwdata[BIT_PSR_ASYNC] || asyncPrescalerReset);
            if (!hwdata[BIT_SYNC_HOLD] && hwdata[BIT_PSR_SYNC]) begin
                syncPrescalerReset <= 1'b1;
            end
        end else if (!syncHoldMode) begin
            syncPrescalerReset <= 1'b0;
            asyncPrescalerReset <= 1'b0;
        end
    end

    tmr_prescaler prescaler (
        .clk(clk),
        .rst_b(rst_b),
        .clear(syncPrescalerReset),
        .tick8(t8),
        .tick64(t64),
        .tick256(t256),
        .tick1024(t1024)
    );

    // Two sync stages and an edge stage: count lands 2 to 3 clocks after the pin
    tmr_ext_edge extEdge (
        .clk(clk),
        .rst_b(rst_b),
        .pinIn(extCountPin),
        .rise(rise),
        .fall(fall)
    );

    // Taps shared with the second timer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prescaleTick8 <= 1'b0;
            prescaleTick64 <= 1'b0;
            prescaleTick256 <= 1'b0;
            prescaleTick1024 <= 1'b0;
        end else begin
            prescaleTick8 <= t8;
            prescaleTick64 <= t64;
            prescaleTick256 <= t256;
            prescaleTick1024 <= t1024;
        end
    end

    // ---------------------------------------------------------------
    // Clock select
    // ---------------------------------------------------------------
    // Held prescaler reset halts every internally clocked source
    always_comb begin
        case (clockSrcSel)
            CS_STOP: tick = 1'b0;
            CS_DIRECT: tick = !syncPrescalerReset;
            CS_DIV8: tick = t8;
            CS_DIV64: tick = t64;
            CS_DIV256: tick = t256;
            CS_DIV1024: tick = t1024;
            CS_EXT_FALL: tick = fall;
            CS_EXT_RISE: tick = rise;
            default: tick = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    // Reserved mode codes fall back to the full 8-bit range
    always_comb begin
        case (wm)
            WM_CTC, WM_PC_OCRA, WM_FAST_OCRA: top = compareAValue;
            default: top = COUNT_MAX;
        endcase
    end

    always_comb begin
        next_count = counterValue + 8'h01;
        next_down = countDown;
        ovfEvent = 1'b0;
        case (wm)
            WM_PC_FF, WM_PC_OCRA: begin
                // Direction turns on arrival, so bottom is seen while counting up
                ovfEvent = (counterValue == COUNT_BOTTOM);
                if (countDown) begin
                    next_count = counterValue - 8'h01;
                    if (counterValue == COUNT_BOTTOM + 8'h01) begin
                        next_down = 1'b0;
                    end
                    if (counterValue == COUNT_BOTTOM) begin
                        next_count = COUNT_BOTTOM + 8'h01;
                        next_down = 1'b0;
                    end
                end else if (counterValue >= top) begin
                    next_count = counterValue - 8'h01;
                    next_down = 1'b1;
                end
            end
            WM_CTC: begin
                ovfEvent = (counterValue == COUNT_MAX);
                if (counterValue == top) begin
                    next_count = COUNT_BOTTOM;
                end
            end
            WM_FAST_OCRA: begin
                ovfEvent = (counterValue == top);
                if (counterValue == top) begin
                    next_count = COUNT_BOTTOM;
                end
            end
            default: begin
                ovfEvent = (counterValue == COUNT_MAX);
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            counterValue <= RESET_BYTE;
            countDown <= 1'b0;
        end else if (wrCounter) begin
            counterValue <= hwdata[7:0];
        end else if (tick) begin
            counterValue <= next_count;
            countDown <= next_down;
        end
    end

    // Match from a software-written value would be spurious
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            blockMatch <= 1'b0;
        end else if (wrCounter) begin
            blockMatch <= 1'b1;
        end else if (tick) begin
            blockMatch <= 1'b0;
        end
    end

    // Compared every cycle, acted on at the timer tick
    assign matchA = tick && !blockMatch && (counterValue == compareAValue);
    assign matchB = tick && !blockMatch && (counterValue == compareBValue);

    // ---------------------------------------------------------------
    // Flags and requests
    // ---------------------------------------------------------------
    // Set wins over clear so an event in the clear cycle survives
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqFlagBits <= 3'h0;
        end else begin
            irqFlagBits[BIT_OVF] <= (tick && ovfEvent) ||
                (irqFlagBits[BIT_OVF] && !ackOvf &&
                 !(wrFlag && hwdata[BIT_OVF]));
            irqFlagBits[BIT_CMPA] <= matchA ||
                (irqFlagBits[BIT_CMPA] && !ackCmpA &&
                 !(wrFlag && hwdata[BIT_CMPA]));
            irqFlagBits[BIT_CMPB] <= matchB ||
                (irqFlagBits[BIT_CMPB] && !ackCmpB &&
                 !(wrFlag && hwdata[BIT_CMPB]));
        end
    end

    // Level request; a cleared flag drops it one cycle later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqOvf <= 1'b0;
            irqCmpA <= 1'b0;
            irqCmpB <= 1'b0;
        end else begin
            irqOvf <= globalIrqEn && irqEnableBits[BIT_OVF] && irqFlagBits[BIT_OVF];
            irqCmpA <= globalIrqEn && irqEnableBits[BIT_CMPA] && irqFlagBits[BIT_CMPA];
            irqCmpB <= globalIrqEn && irqEnableBits[BIT_CMPB] && irqFlagBits[BIT_CMPB];
        end
    end

    // Toggle on match; output compare modes beyond that are outside this block
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            waveOutA <= 1'b0;
            waveOutB <= 1'b0;
        end else begin
            if (matchA) begin
                waveOutA <= !waveOutA;
            end
            if (matchB) begin
                waveOutB <= !waveOutB;
            end
        end
    end
endmodule

// *** hw/tmr_pkg.sv ***
package tmr_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_COUNTER = 8'h00;
    localparam logic [7:0] ADDR_CMP_A = 8'h04;
    localparam logic [7:0] ADDR_CMP_B = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_FLAG = 8'h10;
    localparam logic [7:0] ADDR_SYNC_CTRL = 8'h14;
    localparam logic [7:0] ADDR_CONTROL = 8'h18;
    // ---------------------------------------------------------------
    // Fields
    // ---------------------------------------------------------------
    localparam int BIT_OVF = 0;
    localparam int BIT_CMPA = 1;
    localparam int BIT_CMPB = 2;
    localparam int BIT_PSR_SYNC = 0;
    localparam int BIT_PSR_ASYNC = 1;
    localparam int BIT_SYNC_HOLD = 7;
    localparam int CTRL_CS_LSB = 0;
    localparam int CTRL_WGM_LSB = 4;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    // ---------------------------------------------------------------
    // Clock select codes
    // ---------------------------------------------------------------
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIRECT = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam int PRESCALE_BITS = 10;
    localparam logic [9:0] PRESCALE_MASK8 = 10'h007;
    localparam logic [9:0] PRESCALE_MASK64 = 10'h03F;
    localparam logic [9:0] PRESCALE_MASK256 = 10'h0FF;
    localparam logic [9:0] PRESCALE_MASK1024 = 10'h3FF;
    // ---------------------------------------------------------------
    // Wave modes
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        WM_NORMAL = 3'h0,
        WM_PC_FF = 3'h1,
        WM_CTC = 3'h2,
        WM_FAST_FF = 3'h3,
        WM_RSV4 = 3'h4,
        WM_PC_OCRA = 3'h5,
        WM_RSV6 = 3'h6,
        WM_FAST_OCRA = 3'h7
    } tmr_wave_t;
endpackage

// *** hw/tmr_prescaler.sv ***
`timescale 1ns/10ps
module tmr_prescaler
    import tmr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clear,
    output logic tick8,
    output logic tick64,
    output logic tick256,
    output logic tick1024
);
    logic [PRESCALE_BITS-1:0] count;

    // Free running; clear restarts all taps for every timer attached
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else begin
            count <= count + 10'h001;
        end
    end

    // Taps fire when the low bits roll over
    assign tick8 = !clear && ((count & PRESCALE_MASK8) == PRESCALE_MASK8);
    assign tick64 = !clear && ((count & PRESCALE_MASK64) == PRESCALE_MASK64);
    assign tick256 = !clear && ((count & PRESCALE_MASK256) == PRESCALE_MASK256);
    assign tick1024 = !clear && (count == PRESCALE_MASK1024);
endmodule

// *** hw/tmr_ext_edge.sv ***
`timescale 1ns/10ps
module tmr_ext_edge
    import tmr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pinIn,
    output logic rise,
    output logic fall
);
    logic sync1;
    logic sync2;
    logic prev;

    // Two stages against metastability, then one for edge history
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
        end else begin
            sync1 <= pinIn;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    assign rise = sync2 && !prev;
    assign fall = !sync2 && prev;
endmodule

// *** dv/tmr_top_sva.sv ***
`timescale 1ns/10ps
module tmr_top_chk
    import tmr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic globalIrqEn,
    input wire logic ackOvf,
    input wire logic irqOvf,
    input wire logic irqCmpA,
    input wire logic irqCmpB,
    input wire logic prescaleTick8,
    input wire logic prescaleTick64,
    input wire logic prescaleTick256,
    input wire logic prescaleTick1024
);
    // ------------------------------
    // Data phase tracking
    // ------------------------------
    logic rdPhase;
    logic wrPhase;
    logic [7:0] rdAddr;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdPhase <= 1'b0;
            wrPhase <= 1'b0;
            rdAddr <= 8'h00;
        end else if (hready) begin
            rdPhase <= hsel & htrans[1] & ~hwrite;
            wrPhase <= hsel & htrans[1] & hwrite;
            rdAddr <= haddr[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ------------------------------
    // Properties
    // ------------------------------
    chk_ovf_irq_gate: assert property (irqOvf |-> $past(globalIrqEn))
        else $error("overflow request without global enable");
    chk_cmpa_irq_gate: assert property (!globalIrqEn |=> !irqCmpA)
        else $error("compare A request without global enable");
    chk_cmpb_irq_gate: assert property (irqCmpB |-> $past(globalIrqEn))
        else $error("compare B request without global enable");
    // A flag or enable register write may drop the request, so all writes are excluded
    chk_irq_level_hold: assert property (irqOvf && globalIrqEn && !ackOvf &&
        !$past(ackOvf) && !wrPhase && !$past(wrPhase) |=> irqOvf)
        else $error("overflow request dropped while flag held");
    chk_flag_rsv_zero: assert property (rdPhase &&
        (rdAddr == ADDR_IRQ_EN || rdAddr == ADDR_IRQ_FLAG) |-> hrdata[31:3] == 29'h0)
        else $error("reserved mask or flag bits read nonzero");
    chk_byte_wide_read: assert property (rdPhase |-> hrdata[31:8] == 24'h0)
        else $error("upper read bits nonzero");
    chk_tick8_spacing: assert property (prescaleTick8 |=> !prescaleTick8 [*7])
        else $error("divide by 8 tap too fast");
    chk_tap64_nest: assert property (prescaleTick64 |-> prescaleTick8)
        else $error("divide by 64 tap off the 8 grid");
    chk_tap256_nest: assert property (prescaleTick256 |-> prescaleTick64)
        else $error("divide by 256 tap off the 64 grid");
    chk_tap1024_nest: assert property (prescaleTick1024 |-> prescaleTick256)
        else $error("divide by 1024 tap off the 256 grid");
endmodule

bind tmr_top tmr_top_chk i_chk (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .globalIrqEn(globalIrqEn), .ackOvf(ackOvf), .irqOvf(irqOvf), .irqCmpA(irqCmpA),
    .irqCmpB(irqCmpB), .prescaleTick8(prescaleTick8), .prescaleTick64(prescaleTick64),
    .prescaleTick256(prescaleTick256), .prescaleTick1024(prescaleTick1024));

// *** dv/tmr_top_tb.sv ***
`timescale 1ns/10ps
module tmr_top_tb
    import tmr_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, globalIrqEn = 1'b0;
    logic ackOvf = 1'b0, ackCmpA = 1'b0, ackCmpB = 1'b0, extCountPin = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, irqOvf, irqCmpA, irqCmpB, waveOutA, waveOutB, wa, wb;
    logic asyncPrescalerReset, prescaleTick8, prescaleTick64, prescaleTick256, prescaleTick1024;
    int failCount = 0, nTests = 0, cycles = 0, k;
    int divs[5] = '{1, 8, 64, 256, 1024};

    always #4 clk = ~clk;

    tmr_top i_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .globalIrqEn(globalIrqEn),
        .ackOvf(ackOvf), .ackCmpA(ackCmpA), .ackCmpB(ackCmpB), .extCountPin(extCountPin),
        .otherTimerTick(1'b0), .irqOvf(irqOvf), .irqCmpA(irqCmpA), .irqCmpB(irqCmpB),
        .waveOutA(waveOutA), .waveOutB(waveOutB), .asyncPrescalerReset(asyncPrescalerReset),
        .prescaleTick8(prescaleTick8), .prescaleTick64(prescaleTick64),
        .prescaleTick256(prescaleTick256), .prescaleTick1024(prescaleTick1024));

    // ------------------------------
    // Bus and check tasks
    // ------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        v = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        check(v, exp);
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(a, 1'b0, 32'h0);
    endtask

    task automatic runm(input logic [2:0] m, input int n);
        wr(ADDR_CONTROL, {25'h0, m, 1'b0, CS_DIRECT});
        repeat (n) @(posedge clk);
        wr(ADDR_CONTROL, 32'h0);
    endtask

    task automatic run(input logic [2:0] cs, input int n);
        wr(ADDR_CONTROL, {29'h0, cs});
        repeat (n) @(posedge clk);
        wr(ADDR_CONTROL, 32'h0);
    endtask

    task automatic ticks(input int n);
        k = 0;
        repeat (n) begin
            @(posedge clk);
            if (prescaleTick8 === 1'b1) k++;
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // A hang costs one mismatch, then the normal report
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failCount++;
            report_and_stop;
        end
    end

    // ------------------------------
    // Tests
    // ------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        foreach (divs[i]) rdchk(8'(4 * i), {24'h0, RESET_BYTE});
        wr(ADDR_IRQ_EN, 32'hFFFFFFFF);
        rdchk(ADDR_IRQ_EN, 32'h7);
        wr(8'h1C, 32'hFF);
        rdchk(8'h1C, 32'h0);
        check({30'h0, hreadyout, hresp}, 32'h2);
        $display("registers done");
        foreach (divs[i]) begin
            wr(ADDR_COUNTER, 32'h0);
            run(CS_DIRECT + 3'(i), 8 * divs[i]);
            rd(ADDR_COUNTER);
            check(v & 32'hFFFF_FF00, 32'h0);
            // Free running taps: first count lands anywhere in one period
            check({31'h0, v >= (i == 0 ? 9 : 7) && v <= (i == 0 ? 11 : 9)}, 32'h1);
        end
        rdchk(ADDR_COUNTER, v);
        repeat (20) @(posedge clk);
        rdchk(ADDR_COUNTER, v);
        $display("rates done");
        wr(ADDR_IRQ_FLAG, 32'hFF);
        wr(ADDR_CMP_A, 32'h20);
        wr(ADDR_CMP_B, 32'h21);
        wr(ADDR_COUNTER, 32'h1E);
        wa = waveOutA;
        wb = waveOutB;
        globalIrqEn <= 1'b1;
        run(CS_DIRECT, 3);
        rdchk(ADDR_IRQ_FLAG, 32'h6);
        check(irqCmpA, 1'b1);
        check(irqCmpB, 1'b1);
        check(irqOvf, 1'b0);
        check({waveOutA, waveOutB}, {~wa, ~wb});
        globalIrqEn <= 1'b0;
        repeat (2) @(posedge clk);
        check(irqCmpA, 1'b0);
        globalIrqEn <= 1'b1;
        ackCmpA <= 1'b1;
        @(posedge clk);
        ackCmpA <= 1'b0;
        rdchk(ADDR_IRQ_FLAG, 32'h4);
        wr(ADDR_IRQ_FLAG, 32'h0);
        rdchk(ADDR_IRQ_FLAG, 32'h4);
        wr(ADDR_IRQ_FLAG, 32'h4);
        rdchk(ADDR_IRQ_FLAG, 32'h0);
        wr(ADDR_CMP_A, 32'h40);
        wr(ADDR_COUNTER, 32'h40);
        run(CS_DIRECT, 2);
        rdchk(ADDR_IRQ_FLAG, 32'h0);
        wr(ADDR_COUNTER, 32'hFD);
        run(CS_DIRECT, 3);
        rdchk(ADDR_IRQ_FLAG, 32'h1);
        check(irqOvf, 1'b1);
        wr(ADDR_IRQ_EN, 32'h6);
        repeat (2) @(posedge clk);
        check(irqOvf, 1'b0);
        ackOvf <= 1'b1;
        @(posedge clk);
        ackOvf <= 1'b0;
        rdchk(ADDR_IRQ_FLAG, 32'h0);
        wr(ADDR_IRQ_FLAG, 32'h7);
        wr(ADDR_CMP_A, 32'h5);
        wr(ADDR_COUNTER, 32'h0);
        runm(WM_CTC, 8);
        rdchk(ADDR_COUNTER, 32'h4);
        wr(ADDR_IRQ_FLAG, 32'h7);
        wr(ADDR_COUNTER, 32'h3);
        runm(WM_PC_OCRA, 6);
        rdchk(ADDR_IRQ_FLAG, 32'h3);
        rdchk(ADDR_COUNTER, 32'h1);
        $display("flags done");
        for (int e = 0; e < 2; e++) begin
            wr(ADDR_COUNTER, 32'h0);
            // Pin held low and stable while the source is switched
            wr(ADDR_CONTROL, {29'h0, e ? CS_EXT_FALL : CS_EXT_RISE});
            repeat (5) begin
                extCountPin <= 1'b1;
                repeat (4) @(posedge clk);
                extCountPin <= 1'b0;
                repeat (4) @(posedge clk);
            end
            wr(ADDR_CONTROL, 32'h0);
            rdchk(ADDR_COUNTER, 32'h5);
        end
        $display("external done");
        wr(ADDR_SYNC_CTRL, 32'h1);
        // Set for one cycle, so only the back-to-back read still sees it
        rdchk(ADDR_SYNC_CTRL, 32'h1);
        rdchk(ADDR_SYNC_CTRL, 32'h0);
        wr(ADDR_SYNC_CTRL, 32'h83);
        rdchk(ADDR_SYNC_CTRL, 32'h83);
        check(asyncPrescalerReset, 1'b1);
        ticks(40);
        check(k, 0);
        wr(ADDR_SYNC_CTRL, 32'h0);
        rdchk(ADDR_SYNC_CTRL, 32'h0);
        check(asyncPrescalerReset, 1'b0);
        ticks(16);
        check(k, 2);
        $display("prescaler done");
        report_and_stop;
    end
endmodule
